// [hw/cmp_sel_pkg.sv]
package cmp_sel_pkg;
  // ------------------------------------------------------------------
  // special-function-register addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CMP1_MODE = 8'h9c;
  localparam logic [7:0] ADDR_CMP1_INSEL = 8'h9e;
  localparam logic [7:0] ADDR_CMP0_INSEL = 8'h9f;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int RISE_IE_BIT = 5;
  localparam int FALL_IE_BIT = 4;
  localparam int MODE_LSB = 0;
  localparam int POS_SEL_LSB = 0;
  localparam int NEG_SEL_LSB = 4;
  // writable bits; everything else reads zero
  localparam logic [7:0] MODE_WMASK = 8'h33;
  localparam logic [7:0] INSEL_WMASK = 8'h77;
  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h02;
  localparam logic [7:0] INSEL_RESET = 8'h00;
  // highest legal selector code
  localparam logic [2:0] SEL_MAX = 3'h4;
  localparam logic [2:0] SEL_GAP_SMALL = 3'h3;
endpackage

// [hw/cmp_sel_decode.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// selector code to one-hot pin enable
// ------------------------------------------------------------------
module cmp_sel_decode #(
  parameter bit GAP_ON_SMALL = 1'b0
) (
  input wire logic [2:0] code,
  input wire logic small_pkg,
  output logic [4:0] pin_en
);
  always_comb begin
    pin_en = 5'h00;
    // reserved codes leave the comparator input floating
    if (code <= cmp_sel_pkg::SEL_MAX &&
        !(GAP_ON_SMALL && small_pkg && code == cmp_sel_pkg::SEL_GAP_SMALL)) begin
      pin_en[code] = 1'b1;
    end
  end
endmodule // cmp_sel_decode
`default_nettype wire

// [hw/cmp_sel_regs.sv]
// Overview of operation
// - mode register bits 7:6 and 3:2 read zero and ignore writes.
// - mode bit 5 is a read/write enable letting a rising edge request an interrupt.
// - mode bit 4 is a read/write enable letting a falling edge request an interrupt.
// - mode bits 1:0 pick one of four speed/power response modes driven to comparator1.
// - each input select register has a 3-bit positive input field in bits 2:0.
// - each input select register has a 3-bit negative input field in bits 6:4.
// - comparator0 negative codes 0-4 map to five pins per package, codes 5-7 reserved.
// - comparator1 negative code 3 is reserved on the small package, codes 5-7 on both.
// - comparator1 positive code 3 is reserved on the small package, codes 5-7 on both.
// - input select bits 7 and 3 read zero and ignore writes.
// - the rise flag sets on each rising comparator1 output edge until software clears it.
// - the fall flag sets on each falling comparator1 output edge until software clears it.
`timescale 1ns/1ns
`default_nettype none
module cmp_sel_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic small_pkg,
  input wire logic cmp1_out,
  input wire logic flag_clr_rise,
  input wire logic flag_clr_fall,
  output logic cmp1_rise_flag,
  output logic cmp1_fall_flag,
  output logic cmp1_irq,
  output logic [1:0] cmp1_response_mode,
  output logic [4:0] cmp0_pos_pin_en,
  output logic [4:0] cmp0_neg_pin_en,
  output logic [4:0] cmp1_pos_pin_en,
  output logic [4:0] cmp1_neg_pin_en
);
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] mode_reg, next_mode_reg;
  logic [7:0] in1_reg, next_in1_reg;
  logic [7:0] in0_reg, next_in0_reg;
  logic [7:0] next_sfr_rdata;
  logic small_s1, small_s2, cmp_s1, cmp_s2, cmp_d;
  logic next_rise, next_fall, next_irq;
  logic [4:0] d0p, d0n, d1p, d1n;
  logic cmp1_rise_irq_enable, cmp1_fall_irq_enable;

  assign cmp1_rise_irq_enable = mode_reg[cmp_sel_pkg::RISE_IE_BIT];
  assign cmp1_fall_irq_enable = mode_reg[cmp_sel_pkg::FALL_IE_BIT];

  always_comb begin
    next_mode_reg = mode_reg;
    next_in1_reg = in1_reg;
    next_in0_reg = in0_reg;
    if (sfr_wr) begin
      unique case (sfr_addr)
        cmp_sel_pkg::ADDR_CMP1_MODE: begin
          next_mode_reg = sfr_wdata & cmp_sel_pkg::MODE_WMASK;
        end
        cmp_sel_pkg::ADDR_CMP1_INSEL: begin
          next_in1_reg = sfr_wdata & cmp_sel_pkg::INSEL_WMASK;
        end
        cmp_sel_pkg::ADDR_CMP0_INSEL: begin
          next_in0_reg = sfr_wdata & cmp_sel_pkg::INSEL_WMASK;
        end
        default: begin
        end
      endcase
    end
    // registered read data; unmapped addresses read zero
    next_sfr_rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        cmp_sel_pkg::ADDR_CMP1_MODE: next_sfr_rdata = mode_reg;
        cmp_sel_pkg::ADDR_CMP1_INSEL: next_sfr_rdata = in1_reg;
        cmp_sel_pkg::ADDR_CMP0_INSEL: next_sfr_rdata = in0_reg;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= cmp_sel_pkg::MODE_RESET;
      in1_reg <= cmp_sel_pkg::INSEL_RESET;
      in0_reg <= cmp_sel_pkg::INSEL_RESET;
      sfr_rdata <= 8'h00;
    end else begin
      mode_reg <= next_mode_reg;
      in1_reg <= next_in1_reg;
      in0_reg <= next_in0_reg;
      sfr_rdata <= next_sfr_rdata;
    end
  end

  // ------------------------------------------------------------------
  // edge flags
  // ------------------------------------------------------------------
  // comparator output is asynchronous, so it is synchronised first
  always_comb begin
    // set beats clear so an edge in the clearing cycle is kept
    next_rise = (cmp_s2 && !cmp_d) || (cmp1_rise_flag && !flag_clr_rise);
    next_fall = (!cmp_s2 && cmp_d) || (cmp1_fall_flag && !flag_clr_fall);
    next_irq = (next_rise && next_mode_reg[cmp_sel_pkg::RISE_IE_BIT]) ||
               (next_fall && next_mode_reg[cmp_sel_pkg::FALL_IE_BIT]);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_d <= 1'b0;
      small_s1 <= 1'b0;
      small_s2 <= 1'b0;
      cmp1_rise_flag <= 1'b0;
      cmp1_fall_flag <= 1'b0;
      cmp1_irq <= 1'b0;
    end else begin
      cmp_s1 <= cmp1_out;
      cmp_s2 <= cmp_s1;
      cmp_d <= cmp_s2;
      small_s1 <= small_pkg;
      small_s2 <= small_s1;
      cmp1_rise_flag <= next_rise;
      cmp1_fall_flag <= next_fall;
      cmp1_irq <= next_irq;
    end
  end

  // ------------------------------------------------------------------
  // mux decode
  // ------------------------------------------------------------------
  cmp_sel_decode #(.GAP_ON_SMALL(1'b0)) u_d0p (
    .code(in0_reg[cmp_sel_pkg::POS_SEL_LSB +: 3]), .small_pkg(small_s2), .pin_en(d0p));
  cmp_sel_decode #(.GAP_ON_SMALL(1'b0)) u_d0n (
    .code(in0_reg[cmp_sel_pkg::NEG_SEL_LSB +: 3]), .small_pkg(small_s2), .pin_en(d0n));
  cmp_sel_decode #(.GAP_ON_SMALL(1'b1)) u_d1p (
    .code(in1_reg[cmp_sel_pkg::POS_SEL_LSB +: 3]), .small_pkg(small_s2), .pin_en(d1p));
  cmp_sel_decode #(.GAP_ON_SMALL(1'b1)) u_d1n (
    .code(in1_reg[cmp_sel_pkg::NEG_SEL_LSB +: 3]), .small_pkg(small_s2), .pin_en(d1n));

  // enables registered so analog switches see glitch-free levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp1_response_mode <= cmp_sel_pkg::MODE_RESET[cmp_sel_pkg::MODE_LSB +: 2];
      cmp0_pos_pin_en <= 5'h00;
      cmp0_neg_pin_en <= 5'h00;
      cmp1_pos_pin_en <= 5'h00;
      cmp1_neg_pin_en <= 5'h00;
    end else begin
      cmp1_response_mode <= mode_reg[cmp_sel_pkg::MODE_LSB +: 2];
      cmp0_pos_pin_en <= d0p;
      cmp0_neg_pin_en <= d0n;
      cmp1_pos_pin_en <= d1p;
      cmp1_neg_pin_en <= d1n;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence rise_seen_s;
    cmp_s2 && !cmp_d;
  endsequence
  sequence fall_seen_s;
    !cmp_s2 && cmp_d;
  endsequence

  unused_mode_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
    (mode_reg & ~cmp_sel_pkg::MODE_WMASK) == 8'h00) else $error("mode unused bits set");
  unused_sel_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((in0_reg | in1_reg) & ~cmp_sel_pkg::INSEL_WMASK) == 8'h00) else $error("sel unused bits set");
  rise_irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmp1_rise_flag && cmp1_rise_irq_enable |-> cmp1_irq) else $error("rise irq missing");
  fall_irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmp1_fall_flag && cmp1_fall_irq_enable |-> cmp1_irq) else $error("fall irq missing");
  irq_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmp1_irq |-> (cmp1_rise_flag && cmp1_rise_irq_enable) ||
                 (cmp1_fall_flag && cmp1_fall_irq_enable)) else $error("irq without cause");
  rise_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    rise_seen_s |=> cmp1_rise_flag) else $error("rise flag not set");
  fall_flag_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    !cmp_s2 && cmp_d |=> cmp1_fall_flag) else $error("fall flag not set");
  rise_flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmp1_rise_flag && !flag_clr_rise |=> cmp1_rise_flag) else $error("rise flag lost");
  mode_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmp1_response_mode == $past(mode_reg[1:0])) else $error("mode not driven");
  reserved_float_a: assert property (@(posedge clk) disable iff (!rst_b)
    in1_reg[2:0] > 3'h4 |=> cmp1_pos_pin_en == 5'h00) else $error("reserved code drives pin");
  one_hot_a: assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(cmp0_neg_pin_en)) else $error("multiple pins selected");

  // flag hold and clear, both polarities
  fall_flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmp1_fall_flag && !flag_clr_fall |=> cmp1_fall_flag) else $error("fall flag lost");
  rise_flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    flag_clr_rise && !(cmp_s2 && !cmp_d) |=> !cmp1_rise_flag) else $error("rise flag stuck");
  fall_flag_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    flag_clr_fall && !(!cmp_s2 && cmp_d) |=> !cmp1_fall_flag) else $error("fall flag stuck");
  // set wins: an edge landing in the clearing cycle must not be lost
  rise_set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    rise_seen_s ##0 flag_clr_rise |=> cmp1_rise_flag) else $error("rise edge lost to clear");
  fall_set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    fall_seen_s ##0 flag_clr_fall |=> cmp1_fall_flag) else $error("fall edge lost to clear");
  rise_irq_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !cmp1_rise_irq_enable && !cmp1_fall_flag |-> !cmp1_irq) else $error("irq with rise off");
  fall_irq_off_a: assert property (@(posedge clk) disable iff (!rst_b)
    !cmp1_fall_irq_enable && !cmp1_rise_flag |-> !cmp1_irq) else $error("irq with fall off");

  // pin maps follow the stored code one cycle later
  cmp0_pos_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in0_reg[2:0] <= cmp_sel_pkg::SEL_MAX |=> cmp0_pos_pin_en[$past(in0_reg[2:0])])
    else $error("cmp0 pos pin wrong");
  cmp0_neg_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    in0_reg[6:4] <= cmp_sel_pkg::SEL_MAX |=> cmp0_neg_pin_en[$past(in0_reg[6:4])])
    else $error("cmp0 neg pin wrong");
  cmp1_pos_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    !small_s2 && in1_reg[2:0] <= cmp_sel_pkg::SEL_MAX |=> cmp1_pos_pin_en[$past(in1_reg[2:0])])
    else $error("cmp1 pos pin wrong");
  // small package has no pin behind code 3 on comparator1
  cmp1_neg_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    small_s2 && in1_reg[6:4] == cmp_sel_pkg::SEL_GAP_SMALL |=> cmp1_neg_pin_en == 5'h00)
    else $error("cmp1 neg gap drives pin");
  cmp1_pos_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
    small_s2 && in1_reg[2:0] == cmp_sel_pkg::SEL_GAP_SMALL |=> cmp1_pos_pin_en == 5'h00)
    else $error("cmp1 pos gap drives pin");
endmodule // cmp_sel_regs
`default_nettype wire

// [dv/cmp_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module cmp_core_model (
  input wire logic level_req,
  input wire logic [1:0] response_mode,
  output logic cmp_out
);
  // slower modes settle later, async to clk; one process owns the output
  initial begin
    cmp_out = 1'b0;
    forever begin
      @(level_req);
      cmp_out <= #(5 + 10 * response_mode) level_req;
    end
  end
endmodule // cmp_core_model
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, small_pkg = 1'b0, lvl = 1'b0;
  logic clr_r = 1'b0, clr_f = 1'b0, rd_seen = 1'b0, rf, ff, irq, c1;
  logic pulse_seen = 1'b0, irq_seen = 1'b0;
  logic [1:0] rmode;
  logic [4:0] p0, n0, p1, n1;
  logic [7:0] exp_q[$];
  logic [15:0] rng = 16'h67d6;
  int err_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  cmp_core_model u_model (.level_req(lvl), .response_mode(rmode), .cmp_out(c1));
  cmp_sel_regs u_dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata), .small_pkg(small_pkg),
    .cmp1_out(c1), .flag_clr_rise(clr_r), .flag_clr_fall(clr_f), .cmp1_rise_flag(rf),
    .cmp1_fall_flag(ff), .cmp1_irq(irq), .cmp1_response_mode(rmode),
    .cmp0_pos_pin_en(p0), .cmp0_neg_pin_en(n0), .cmp1_pos_pin_en(p1),
    .cmp1_neg_pin_en(n1));
  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] xs(logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction
  function automatic logic [7:0] pin(logic [2:0] c, logic gap);
    return (c > 3'h4 || (gap && c == 3'h3)) ? 8'h00 : 8'h01 << c;
  endfunction
  // one bus cycle; every strobe set once per step, so calls chain safely
  task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
    sfr_wr = w;
    sfr_rd = r;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic wflag(logic f);
    // look one step after each edge, never in the edge's own time step
    for (int k = 0; k < 20 && (f ? ff : rf) !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  always @(posedge clk) rd_seen <= sfr_rd;
  always @(negedge clk) begin
    if (rd_seen && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), rdata);
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    rd(8'h9c, 8'h02);
    rd(8'h9e, 8'h00);
    rd(8'h9f, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      bus(1'b1, 1'b0, 8'h9c, rng[7:0]);
      rd(8'h9c, rng[7:0] & 8'h33);
      idle(1);
      chk("mode", {6'h00, rng[1:0]}, {6'h00, rmode});
      bus(1'b1, 1'b0, 8'h9e, rng[15:8]);
      bus(1'b1, 1'b0, 8'h9f, rng[7:0]);
      rd(8'h9e, rng[15:8] & 8'h77);
      rd(8'h9f, rng[7:0] & 8'h77);
    end
    bus(1'b1, 1'b0, 8'h9d, 8'hff);
    rd(8'h9d, 8'h00);
    for (int p = 0; p < 2; p++) begin
      small_pkg = p[0];
      idle(4);
      for (int c = 0; c < 8; c++) begin
        bus(1'b1, 1'b0, 8'h9f, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
        bus(1'b1, 1'b0, 8'h9e, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
        idle(2);
        chk("cmp0_neg", pin(c[2:0], 1'b0), {3'h0, n0});
        chk("cmp0_pos", pin(3'(7 - c), 1'b0), {3'h0, p0});
        chk("cmp1_neg", pin(c[2:0], p[0]), {3'h0, n1});
        chk("cmp1_pos", pin(3'(7 - c), p[0]), {3'h0, p1});
      end
    end
    bus(1'b1, 1'b0, 8'h9c, 8'h23);
    idle(1);
    lvl = 1'b1;
    wflag(1'b0);
    chk("rise", 8'h01, {7'h00, rf});
    chk("irq", 8'h01, {7'h00, irq});
    lvl = 1'b0;
    wflag(1'b1);
    chk("fall", 8'h01, {7'h00, ff});
    clr_r = 1'b1;
    idle(1);
    clr_r = 1'b0;
    idle(1);
    chk("rise", 8'h00, {7'h00, rf});
    chk("irq", 8'h00, {7'h00, irq});
    bus(1'b1, 1'b0, 8'h9c, 8'h10);
    idle(2);
    chk("irq", 8'h01, {7'h00, irq});
    clr_f = 1'b1;
    idle(1);
    clr_f = 1'b0;
    idle(1);
    chk("fall", 8'h00, {7'h00, ff});
    chk("irq", 8'h00, {7'h00, irq});
    // clear held across a rising edge: the edge still shows for one cycle
    clr_r = 1'b1;
    lvl = 1'b1;
    for (int k = 0; k < 12; k++) begin
      idle(1);
      if (rf === 1'b1) pulse_seen = 1'b1;
      if (irq === 1'b1) irq_seen = 1'b1;
    end
    clr_r = 1'b0;
    chk("rise_pulse", 8'h01, {7'h00, pulse_seen});
    chk("irq_off", 8'h00, {7'h00, irq_seen});
    chk("rise", 8'h00, {7'h00, rf});
    end_sim();
  end
endmodule // testbench
`default_nettype wire
